// >>> hdl/dsf_pkg.sv
package dsf_pkg;
  // Frame layout
  localparam int unsigned DSF_FRAME_BITS = 16;
  localparam int unsigned DSF_CTRL_BITS = 4;
  localparam int unsigned DSF_DATA_BITS = 12;
  localparam int unsigned DSF_CNT_W = 5;
  localparam logic [4:0] DSF_LAST_BIT = 5'h10;
  // Control nibble codes
  localparam logic [3:0] DSF_CMD_NOP = 4'h0;
  localparam logic [3:0] DSF_CMD_LOAD = 4'h1;
  localparam logic [3:0] DSF_CMD_CHAIN_OFF = 4'h9;
  localparam logic [3:0] DSF_CMD_RISE_EDGE = 4'ha;
  localparam logic [3:0] DSF_CMD_CLR_ZERO = 4'hb;
  localparam logic [3:0] DSF_CMD_CLR_MID = 4'hc;
  // Reset and clear values
  localparam logic [11:0] DSF_DAC_RST = 12'h000;
  localparam logic [11:0] DSF_DAC_MID = 12'h800;
  localparam logic [15:0] DSF_SHIFT_RST = 16'h0000;
  // Frame state
  typedef enum logic [2:0]
  {
    DSF_IDLE = 3'b001,
    DSF_SHIFT = 3'b010,
    DSF_DONE = 3'b100
  } dsf_state_t;
endpackage : dsf_pkg

// >>> hdl/dsf_frame.sv
module dsf_frame
  import dsf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdin,
  output logic [11:0] dac_value,
  output logic dac_update,
  output logic chain_enabled,
  output logic rise_edge_mode,
  output logic frame_abort,
  output logic [3:0] control_nibble
);

  // Two-stage synchronisers for the three pins
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic sync_n_d_ff;
  logic sclk_d_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 3'h7;
      sync_ff <= 3'h7;
      sync_n_d_ff <= 1'b1;
      sclk_d_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= {sync_n, sclk, sdin};
      sync_ff <= meta_ff;
      sync_n_d_ff <= sync_ff[2];
      sclk_d_ff <= sync_ff[1];
    end
  end

  logic s_sync_n;
  logic s_sclk;
  logic s_din;
  assign s_sync_n = sync_ff[2];
  assign s_sclk = sync_ff[1];
  assign s_din = sync_ff[0];

  // Edge detection on synchronised levels only
  logic sync_fall;
  logic sync_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic sample_edge;
  assign sync_fall = sync_n_d_ff & ~s_sync_n;
  assign sync_rise = ~sync_n_d_ff & s_sync_n;
  assign sclk_fall = sclk_d_ff & ~s_sclk;
  assign sclk_rise = ~sclk_d_ff & s_sclk;
  assign sample_edge = rise_edge_mode ? sclk_rise : sclk_fall;

  // Frame state and bit counter
  dsf_state_t state_ff;
  logic [DSF_CNT_W-1:0] cnt_ff;
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  assign nxt_shift = {shift_ff[14:0], s_din}; // MSB first

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= DSF_IDLE;
      cnt_ff <= '0;
      shift_ff <= DSF_SHIFT_RST;
    end
    else if (sync_fall)
    begin
      // Counter cleared on every new frame start
      state_ff <= DSF_SHIFT;
      cnt_ff <= '0;
    end
    else if (s_sync_n)
    begin
      state_ff <= DSF_IDLE; // Bits ignored outside the frame
    end
    else
    begin
      unique case (state_ff)
        DSF_IDLE:
        begin
          state_ff <= DSF_IDLE;
        end
        DSF_SHIFT:
        begin
          if (sample_edge)
          begin
            shift_ff <= nxt_shift;
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff + 5'h01 == DSF_LAST_BIT)
            begin
              state_ff <= DSF_DONE; // Further clocks wait for a new sync fall
            end
          end
        end
        DSF_DONE:
        begin
          state_ff <= DSF_DONE;
        end
        default:
        begin
          state_ff <= DSF_IDLE;
        end
      endcase
    end
  end

  // Sixteenth bit lands this cycle
  logic frame_end;
  assign frame_end = (state_ff == DSF_SHIFT) && !s_sync_n && !sync_fall && sample_edge
    && (cnt_ff == DSF_LAST_BIT - 5'h01);
  logic [3:0] cmd;
  logic [11:0] data;
  assign cmd = nxt_shift[15:12];
  assign data = nxt_shift[11:0];

  // Command execution; no-op changes only control_nibble
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dac_value <= DSF_DAC_RST;
      dac_update <= 1'b0;
      chain_enabled <= 1'b1; // Host must turn this off itself
      rise_edge_mode <= 1'b0;
      control_nibble <= DSF_CMD_NOP;
    end
    else
    begin
      dac_update <= 1'b0;
      if (frame_end)
      begin
        control_nibble <= cmd;
        unique case (cmd)
          DSF_CMD_LOAD:
          begin
            dac_value <= data;
            dac_update <= 1'b1;
          end
          DSF_CMD_CHAIN_OFF: chain_enabled <= 1'b0;
          DSF_CMD_RISE_EDGE: rise_edge_mode <= 1'b1;
          DSF_CMD_CLR_ZERO:
          begin
            dac_value <= DSF_DAC_RST;
            dac_update <= 1'b1;
          end
          DSF_CMD_CLR_MID:
          begin
            dac_value <= DSF_DAC_MID;
            dac_update <= 1'b1;
          end
          default: ; // No-op and reserved codes ignore data
        endcase
      end
    end
  end

  // Abort pulse when sync rises mid-frame
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frame_abort <= 1'b0;
    end
    else
    begin
      frame_abort <= sync_rise && (state_ff == DSF_SHIFT);
    end
  end

  AST_ABORT_NO_UPDATE: assert property (@(posedge clk) disable iff (rst)
    (sync_rise && state_ff == DSF_SHIFT) |=> !dac_update && frame_abort)
    else $error("aborted frame updated the DAC");
  AST_COUNT_CLEAR: assert property (@(posedge clk) disable iff (rst)
    sync_fall |=> cnt_ff == 5'h00 && state_ff == DSF_SHIFT)
    else $error("counter not cleared on sync fall");
  AST_LOAD: assert property (@(posedge clk) disable iff (rst)
    (frame_end && cmd == DSF_CMD_LOAD) |=> dac_update && dac_value == $past(data))
    else $error("sixteenth bit did not load DAC");
  AST_NOP: assert property (@(posedge clk) disable iff (rst)
    (frame_end && cmd == DSF_CMD_NOP) |=> !dac_update && $stable(dac_value))
    else $error("no-op frame changed DAC");
  AST_DONE_HOLD: assert property (@(posedge clk) disable iff (rst)
    (state_ff == DSF_DONE && !sync_fall) |=> state_ff != DSF_SHIFT)
    else $error("transfer restarted without sync fall");
  AST_IDLE_NO_SHIFT: assert property (@(posedge clk) disable iff (rst)
    s_sync_n |=> $stable(shift_ff))
    else $error("data shifted with sync high");
  AST_CHAIN_OFF: assert property (@(posedge clk) disable iff (rst)
    (frame_end && cmd == DSF_CMD_CHAIN_OFF) |=> !chain_enabled)
    else $error("chain disable not taken");
  AST_UPDATE_ONLY_AT_END: assert property (@(posedge clk) disable iff (rst)
    dac_update |-> $past(frame_end))
    else $error("update without complete frame");
  // Pulses are single cycles so a host strobe counter sees each once
  AST_UPDATE_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    dac_update |=> !dac_update)
    else $error("update pulse longer than one cycle");
  AST_ABORT_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    frame_abort |=> !frame_abort)
    else $error("abort pulse longer than one cycle");
  AST_ABORT_KEEPS_DAC: assert property (@(posedge clk) disable iff (rst)
    (sync_rise && state_ff == DSF_SHIFT) |=> $stable(dac_value))
    else $error("aborted frame changed the DAC");
  AST_RISE_MODE: assert property (@(posedge clk) disable iff (rst)
    (frame_end && cmd == DSF_CMD_RISE_EDGE) |=> rise_edge_mode)
    else $error("rising edge sampling not taken");
  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (rst)
    (state_ff == DSF_SHIFT && !s_sync_n && !sync_fall && sample_edge) |=> shift_ff[0] == $past(s_din))
    else $error("new bit did not enter at the low end");

endmodule // dsf_frame

// >>> tb/dsf_host.sv
module dsf_host
(
  input wire logic clk,
  output logic sync_n,
  output logic sclk,
  output logic sdin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle frame: sync high, clock parked high
  initial
  begin
    sync_n = 1'b1;
    sclk = 1'b1;
    sdin = 1'b0;
  end
  // Sends w[19] downward for n bits; data moves 20 ns clear of both clock edges
  task automatic frame(input logic [19:0] w, input int n);
    sync_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 19; i > 19 - n; i--)
    begin
      sdin = w[i];
      repeat (4) @(negedge clk);
      sclk = 1'b0;
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
    end
    sync_n = 1'b1;
    sdin = ~sdin; // Released line must not look like a held bit
    repeat (4) @(negedge clk);
  endtask
endmodule // dsf_host

// >>> tb/dsf_frame_tb.sv
module dsf_frame_tb
  import dsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sync_n;
  logic sclk;
  logic sdin;
  logic [11:0] dac_value;
  logic dac_update;
  logic chain_enabled;
  logic rise_edge_mode;
  logic frame_abort;
  logic [3:0] control_nibble;
  int n_fail = 0;
  int num_checks = 0;
  int n_upd = 0;
  int n_abt = 0;
  always #2.5 clk = ~clk;
  // Pulses are counted, so a check need not land on their one cycle
  always @(negedge clk)
  begin
    n_upd += (dac_update === 1'b1);
    n_abt += (frame_abort === 1'b1);
  end
  dsf_host host(.clk(clk), .sync_n(sync_n), .sclk(sclk), .sdin(sdin));
  dsf_frame dut(.clk(clk), .rst(rst), .sync_n(sync_n), .sclk(sclk), .sdin(sdin), .dac_value(dac_value),
    .dac_update(dac_update), .chain_enabled(chain_enabled), .rise_edge_mode(rise_edge_mode),
    .frame_abort(frame_abort), .control_nibble(control_nibble));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One frame, settle time for the synchronisers, then DAC value, control nibble and pulse counts judged
  task automatic xfer(input logic [19:0] w, input int n, input logic [11:0] dac, input logic [3:0] nib,
    input int du, input int da);
    int u0;
    int a0;
    u0 = n_upd;
    a0 = n_abt;
    host.frame(w, n);
    repeat (8) @(negedge clk);
    check(dac_value, dac);
    check(12'(control_nibble), 12'(nib));
    check(12'(n_upd - u0), 12'(du));
    check(12'(n_abt - a0), 12'(da));
  endtask
  task automatic t_reset;
    check(dac_value, DSF_DAC_RST);
    check(12'(chain_enabled), 12'h001);
    check(12'(rise_edge_mode), 12'h000);
    check(12'(control_nibble), 12'(DSF_CMD_NOP));
  endtask
  // Reset in mid-run must bring back chained mode and falling-edge sampling
  task automatic t_rerun_reset;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset;
  endtask
  task automatic t_chain_off;
    xfer({DSF_CMD_CHAIN_OFF, 12'h3c5, 4'h0}, 16, DSF_DAC_RST, DSF_CMD_CHAIN_OFF, 0, 0);
    check(12'(chain_enabled), 12'h000);
  endtask
  // Extra clocks after the sixteenth must not shift or reload
  task automatic t_load;
    xfer({DSF_CMD_LOAD, 12'habc, 4'h0}, 16, 12'habc, DSF_CMD_LOAD, 1, 0);
    xfer({DSF_CMD_LOAD, 12'h123, 4'h5}, 20, 12'h123, DSF_CMD_LOAD, 1, 0);
  endtask
  task automatic t_abort;
    xfer({DSF_CMD_LOAD, 12'hfff, 4'h0}, 10, 12'h123, DSF_CMD_LOAD, 0, 1);
    xfer({DSF_CMD_LOAD, 12'h456, 4'h0}, 16, 12'h456, DSF_CMD_LOAD, 1, 0);
  endtask
  // Reserved codes behave like the no-op
  task automatic t_nop;
    xfer({DSF_CMD_NOP, 12'h7e1, 4'h0}, 16, 12'h456, DSF_CMD_NOP, 0, 0);
    for (int c = 2; c < 16; c++)
    begin
      if (c < 9 || c > 12)
        xfer({4'(c), 12'h5a5, 4'h0}, 16, 12'h456, 4'(c), 0, 0);
    end
  endtask
  task automatic t_clear;
    xfer({DSF_CMD_CLR_MID, 12'h000, 4'h0}, 16, DSF_DAC_MID, DSF_CMD_CLR_MID, 1, 0);
    xfer({DSF_CMD_CLR_ZERO, 12'h000, 4'h0}, 16, DSF_DAC_RST, DSF_CMD_CLR_ZERO, 1, 0);
  endtask
  task automatic t_rise;
    xfer({DSF_CMD_RISE_EDGE, 12'h000, 4'h0}, 16, DSF_DAC_RST, DSF_CMD_RISE_EDGE, 0, 0);
    check(12'(rise_edge_mode), 12'h001);
    xfer({DSF_CMD_LOAD, 12'h9a6, 4'h0}, 16, 12'h9a6, DSF_CMD_LOAD, 1, 0);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset;
    t_chain_off;
    t_load;
    t_abort;
    t_nop;
    t_clear;
    t_rise;
    t_rerun_reset;
    close_out;
  end
endmodule // dsf_frame_tb
